/* design/adc_host_pkg.sv */
package adc_host_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] DIV_OFS    = 8'h04;
	localparam logic [7:0] PERIOD_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0c;
	localparam logic [7:0] DATA_OFS   = 8'h10;
	localparam logic [7:0] LAST_OFS   = 8'h14;
	localparam logic [7:0] FRAMES_OFS = 8'h18;

	// Control fields
	localparam int CTRL_RUN_BIT    = 0;
	localparam int CTRL_BURST_BIT  = 1;
	localparam int CTRL_SINGLE_BIT = 2;

	// Status fields
	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_EMPTY_BIT   = 1;
	localparam int STAT_FULL_BIT    = 2;
	localparam int STAT_OVERRUN_BIT = 3;
	localparam int STAT_PEND_BIT    = 4;
	localparam int STAT_LEVEL_LSB   = 8;

	// Data register fields
	localparam int DATA_VALID_BIT = 31;
	localparam int RESULT_BITS    = 12;

	// Frame lengths in serial clock periods
	localparam logic [4:0] NORMAL_LEN = 5'h10;
	localparam logic [4:0] BURST_LEN  = 5'h08;
	localparam int         WORD_BITS  = 16;

	// Timing: half period of the serial clock in system clocks
	localparam logic [15:0] HALF_DIV_MIN = 16'h0004;
	localparam logic [15:0] HALF_DIV_RST = 16'h0004;
	// Frame spacing in serial clock periods
	localparam logic [15:0] PERIOD_MIN = 16'h0011;
	localparam logic [15:0] PERIOD_RST = 16'h0014;

	// FIFO shape
	localparam int FIFO_DEPTH = 4;

	typedef enum logic {
		ST_IDLE,
		ST_FRAME
	} frame_state_t;

	// Pins driven toward the converter
	typedef struct packed {
		logic sclk;
		logic cs_n;
	} link_out_t;

	// Received word with its kind
	typedef struct packed {
		logic        burst;
		logic [15:0] word;
	} rx_word_t;

endpackage

/* design/bit_sync.sv */
module bit_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] async_in,
	output      logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	// Two stages; only the second stage is looked at outside
	always_comb begin
		s_d = s_q;
		s_d.first = async_in;
		s_d.second = s_q.first;
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.second;

endmodule

/* design/sample_fifo.sv */
module sample_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output      logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output      logic             out_valid,
	input  wire logic             out_ready,
	output      logic [WIDTH-1:0] out_data,
	output      logic [7:0]       level
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0]   DEPTH_C = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST_C  = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 count;
	} fifo_state_t;

	fifo_state_t s_q;
	fifo_state_t s_d;
	logic        push;
	logic        pop;

	// Honest full and empty from the occupancy count
	assign in_ready  = (s_q.count != DEPTH_C);
	assign out_valid = (s_q.count != '0);
	assign out_data  = s_q.mem[s_q.rp];
	assign level     = 8'(s_q.count);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer and count update; wrap works for any depth
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = (s_q.wp == LAST_C) ? '0 : s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = (s_q.rp == LAST_C) ? '0 : s_q.rp + 1'b1;
		end
		if (push && !pop) begin
			s_d.count = s_q.count + 1'b1;
		end else if (pop && !push) begin
			s_d.count = s_q.count - 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule

/* design/adc_serial_host_framer.sv */
// Functional notes
// - Select driven low for each whole word
// - Normal frame is sixteen serial clock periods
// - Power-down burst is eight serial clock periods
// - Host generates the serial clock itself
// - Fresh select assertion for every word
// - Frames start at equal time spacing
// - Clock idles high, data sampled falling edge
// - Frame spacing is whole serial clock periods
// - One select signal also frames reception
// - Word right-justified, result in low bits
// - Burst raises select between edges two and ten
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
module adc_serial_host_framer (
	input  wire logic                   clock,
	input  wire logic                   rstn,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output      logic                   hreadyout,
	output      logic                   hresp,
	output      logic [31:0]            hrdata,
	// Converter link
	output      adc_host_pkg::link_out_t link_out,
	input  wire logic                   serial_result_out
);

	typedef struct packed {
		adc_host_pkg::frame_state_t st;
		logic [15:0]                half_cnt;
		logic                       phase;
		logic [15:0]                slot_cnt;
		logic [4:0]                 bit_cnt;
		logic                       burst;
		logic [15:0]                shift;
		adc_host_pkg::link_out_t    link;
		logic                       run;
		logic                       burst_req;
		logic                       single_req;
		logic [15:0]                div;
		logic [15:0]                period;
		logic                       overrun;
		logic                       wr_pend;
		logic [7:0]                 wr_addr;
		logic [31:0]                rdata;
		logic                       push;
		logic [15:0]                push_word;
		logic [15:0]                last_word;
		logic [31:0]                frames;
	} host_state_t;

	localparam host_state_t RST = '{
		st:         adc_host_pkg::ST_IDLE,
		half_cnt:   16'h0000,
		phase:      1'b1,
		slot_cnt:   16'h0000,
		bit_cnt:    5'h00,
		burst:      1'b0,
		shift:      16'h0000,
		link:       '{sclk: 1'b1, cs_n: 1'b1},
		run:        1'b0,
		burst_req:  1'b0,
		single_req: 1'b0,
		div:        adc_host_pkg::HALF_DIV_RST,
		period:     adc_host_pkg::PERIOD_RST,
		overrun:    1'b0,
		wr_pend:    1'b0,
		wr_addr:    8'h00,
		rdata:      32'h0000_0000,
		push:       1'b0,
		push_word:  16'h0000,
		last_word:  16'h0000,
		frames:     32'h0000_0000
	};

	host_state_t s_q;
	host_state_t s_d;

	logic        data_sync;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        fifo_pop;
	logic [15:0] fifo_out_data;
	logic [7:0]  fifo_level;
	logic        addr_phase;
	logic        tick;
	logic        rise;
	logic        fall;
	logic        slot;

	// Word-aligned register hit on the low address bits
	function automatic logic reg_hit(input logic [31:0] a,
	                                 input logic [7:0]  ofs);
		reg_hit = (a[31:8] == 24'h00_0000) && (a[7:2] == ofs[7:2]);
	endfunction

	// Result right-justified in its word
	function automatic logic [31:0] result_word(input logic [15:0] w);
		result_word = {20'h0_0000, w[adc_host_pkg::RESULT_BITS-1:0]};
	endfunction

	// The returned data line is a pin: two flops before use
	bit_sync #(
		.WIDTH(1)
	) u_data_sync (
		.clock   (clock),
		.rstn    (rstn),
		.async_in(serial_result_out),
		.sync_out(data_sync)
	);

	// Received words wait here until software reads them
	sample_fifo #(
		.WIDTH(16),
		.DEPTH(adc_host_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock    (clock),
		.rstn     (rstn),
		.in_valid (s_q.push),
		.in_ready (fifo_in_ready),
		.in_data  (s_q.push_word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data (fifo_out_data),
		.level    (fifo_level)
	);

	// Bus decode; a read of the data word pops the FIFO
	assign addr_phase = hsel && htrans[1] && hready;
	assign fifo_pop   = addr_phase && !hwrite
	                    && reg_hit(haddr, adc_host_pkg::DATA_OFS);

	// Serial clock grid: one tick per half period
	assign tick = (s_q.half_cnt >= s_q.div - 16'h0001);
	assign rise = tick && !s_q.phase;
	assign fall = tick && s_q.phase;
	assign slot = rise && (s_q.slot_cnt == 16'h0000);

	always_comb begin
		s_d = s_q;
		s_d.push = 1'b0;

		// Writes get one wait state so a following read sees them
		s_d.wr_pend = addr_phase && hwrite;
		if (addr_phase && hwrite) begin
			s_d.wr_addr = haddr[7:0];
		end

		// Read data is latched in the address phase
		if (addr_phase && !hwrite) begin
			s_d.rdata = 32'h0000_0000;
			if (reg_hit(haddr, adc_host_pkg::CTRL_OFS)) begin
				s_d.rdata[adc_host_pkg::CTRL_RUN_BIT] = s_q.run;
			end else if (reg_hit(haddr, adc_host_pkg::DIV_OFS)) begin
				s_d.rdata = {16'h0000, s_q.div};
			end else if (reg_hit(haddr, adc_host_pkg::PERIOD_OFS)) begin
				s_d.rdata = {16'h0000, s_q.period};
			end else if (reg_hit(haddr, adc_host_pkg::STATUS_OFS)) begin
				s_d.rdata[adc_host_pkg::STAT_BUSY_BIT] =
					(s_q.st == adc_host_pkg::ST_FRAME);
				s_d.rdata[adc_host_pkg::STAT_EMPTY_BIT] = !fifo_out_valid;
				s_d.rdata[adc_host_pkg::STAT_FULL_BIT] = !fifo_in_ready;
				s_d.rdata[adc_host_pkg::STAT_OVERRUN_BIT] = s_q.overrun;
				s_d.rdata[adc_host_pkg::STAT_PEND_BIT] =
					s_q.burst_req || s_q.single_req;
				s_d.rdata[adc_host_pkg::STAT_LEVEL_LSB +: 8] = fifo_level;
			end else if (reg_hit(haddr, adc_host_pkg::DATA_OFS)) begin
				// Empty FIFO reads as zero, never a stale word
				if (fifo_out_valid) begin
					s_d.rdata = result_word(fifo_out_data);
				end
				s_d.rdata[adc_host_pkg::DATA_VALID_BIT] = fifo_out_valid;
			end else if (reg_hit(haddr, adc_host_pkg::LAST_OFS)) begin
				s_d.rdata = result_word(s_q.last_word);
			end else if (reg_hit(haddr, adc_host_pkg::FRAMES_OFS)) begin
				s_d.rdata = s_q.frames;
			end
		end

		// Register writes in the data phase
		if (s_q.wr_pend) begin
			case (s_q.wr_addr[7:2])
				adc_host_pkg::CTRL_OFS[7:2]: begin
					s_d.run = hwdata[adc_host_pkg::CTRL_RUN_BIT];
					if (hwdata[adc_host_pkg::CTRL_BURST_BIT]) begin
						s_d.burst_req = 1'b1;
					end
					if (hwdata[adc_host_pkg::CTRL_SINGLE_BIT]) begin
						s_d.single_req = 1'b1;
					end
				end
				adc_host_pkg::DIV_OFS[7:2]: begin
					s_d.div = (hwdata[15:0] < adc_host_pkg::HALF_DIV_MIN)
					          ? adc_host_pkg::HALF_DIV_MIN : hwdata[15:0];
				end
				adc_host_pkg::PERIOD_OFS[7:2]: begin
					// Spacing never shorter than frame plus one period
					s_d.period = (hwdata[15:0] < adc_host_pkg::PERIOD_MIN)
					             ? adc_host_pkg::PERIOD_MIN
					             : hwdata[15:0];
				end
				adc_host_pkg::STATUS_OFS[7:2]: begin
					if (hwdata[adc_host_pkg::STAT_OVERRUN_BIT]) begin
						s_d.overrun = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Internal clock divider, always running
		if (tick) begin
			s_d.half_cnt = 16'h0000;
			s_d.phase = !s_q.phase;
		end else begin
			s_d.half_cnt = s_q.half_cnt + 16'h0001;
		end

		// Slot grid counted in whole serial clock periods
		if (rise) begin
			s_d.slot_cnt = (s_q.slot_cnt == 16'h0000)
			               ? s_q.period - 16'h0001
			               : s_q.slot_cnt - 16'h0001;
			if (s_d.slot_cnt >= s_q.period) begin
				s_d.slot_cnt = s_q.period - 16'h0001;
			end
		end

		case (s_q.st)
			adc_host_pkg::ST_IDLE: begin
				// Clock idles high between frames
				s_d.link.sclk = 1'b1;
				s_d.link.cs_n = 1'b1;
				if (slot) begin
					if (s_q.burst_req) begin
						s_d.burst_req = 1'b0;
						s_d.burst = 1'b1;
						s_d.st = adc_host_pkg::ST_FRAME;
						s_d.link.cs_n = 1'b0;
						s_d.bit_cnt = 5'h00;
					end else if (s_q.run || s_q.single_req) begin
						if (fifo_in_ready) begin
							s_d.single_req = 1'b0;
							s_d.burst = 1'b0;
							s_d.st = adc_host_pkg::ST_FRAME;
							s_d.link.cs_n = 1'b0;
							s_d.bit_cnt = 5'h00;
						end else begin
							// Slot lost: FIFO full keeps the grid intact
							s_d.overrun = 1'b1;
						end
					end
				end
			end
			adc_host_pkg::ST_FRAME: begin
				if (fall) begin
					// First zero already on the line at select fall
					s_d.link.sclk = 1'b0;
					s_d.shift = {s_q.shift[14:0], data_sync};
					s_d.bit_cnt = s_q.bit_cnt + 5'h01;
				end
				if (rise) begin
					s_d.link.sclk = 1'b1;
					if (s_q.burst && s_q.bit_cnt == adc_host_pkg::BURST_LEN) begin
						// Early rise after eighth edge powers down
						s_d.link.cs_n = 1'b1;
						s_d.st = adc_host_pkg::ST_IDLE;
					end else if (!s_q.burst
					             && s_q.bit_cnt == adc_host_pkg::NORMAL_LEN) begin
						s_d.link.cs_n = 1'b1;
						s_d.st = adc_host_pkg::ST_IDLE;
						s_d.push = 1'b1;
						s_d.push_word = s_q.shift;
						s_d.last_word = s_q.shift;
						s_d.frames = s_q.frames + 32'h0000_0001;
					end
				end
			end
			default: begin
				s_d.st = adc_host_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			s_q <= RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Bus answers: writes wait one cycle, reads none
	assign hreadyout = !s_q.wr_pend;
	assign hresp     = 1'b0;
	assign hrdata    = s_q.rdata;
	assign link_out  = s_q.link;

endmodule

/* sim/adc_conv_model.sv */
module adc_conv_model (
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic [11:0] value,
	output      logic        data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] word;
	int          cnt;

	initial begin
		data = 1'b0;
		cnt = 16;
		word = 16'h0000;
	end

	// Select fall samples and shows the first leading zero
	always @(negedge cs_n) begin
		word = {4'h0, value};
		cnt = 0;
		data = word[15];
	end

	// Each clock fall shifts the next bit, released after the last
	always @(negedge sclk) begin
		if (!cs_n && cnt < 16) begin
			cnt++;
			data = (cnt < 16) ? word[15 - cnt] : ~data;
		end
	end

	// Select rise aborts, line released (no pull)
	always @(posedge cs_n) begin
		cnt = 16;
		data = ~data;
	end
endmodule

/* sim/adc_framer_asserts.sv */
module adc_framer_asserts (
	input wire logic                    clock,
	input wire logic                    rstn,
	input wire logic                    hsel,
	input wire logic [1:0]              htrans,
	input wire logic                    hwrite,
	input wire logic                    hready,
	input wire logic                    hreadyout,
	input wire logic                    hresp,
	input wire adc_host_pkg::link_out_t link_out
);
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic       sclk;
		logic       cs_n;
		logic [4:0] falls;
	} mon_t;
	mon_t mon_q;
	mon_t mon_d;

	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	// Count clock falls inside the current frame
	always_comb begin
		mon_d = mon_q;
		mon_d.sclk = link_out.sclk;
		mon_d.cs_n = link_out.cs_n;
		if (mon_q.cs_n && !link_out.cs_n)
			mon_d.falls = 5'h00;
		else if (!link_out.cs_n && mon_q.sclk && !link_out.sclk)
			mon_d.falls = mon_q.falls + 5'h01;
	end

	always_ff @(posedge clock) begin
		if (!rstn)
			mon_q <= '{sclk: 1'b1, cs_n: 1'b1, falls: 5'h00};
		else
			mon_q <= mon_d;
	end

	property p_idle_high;
		link_out.cs_n |-> link_out.sclk;
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("sclk low outside frame");
	property p_first_half;
		$fell(link_out.cs_n) |-> link_out.sclk [*4];
	endproperty
	a_first_half: assert property (p_first_half)
		else $error("sclk fell early");
	property p_fall_in_frame;
		$fell(link_out.sclk) |-> !link_out.cs_n;
	endproperty
	a_fall_in_frame: assert property (p_fall_in_frame)
		else $error("stray fall");
	property p_len;
		$rose(link_out.cs_n) |-> mon_q.falls == 5'h10 || mon_q.falls == 5'h08;
	endproperty
	a_len: assert property (p_len)
		else $error("bad frame length");
	property p_word_bound;
		!link_out.cs_n |-> mon_q.falls <= 5'h10;
	endproperty
	a_word_bound: assert property (p_word_bound)
		else $error("frame overlong");
	property p_rise_with;
		$rose(link_out.cs_n) |-> $rose(link_out.sclk);
	endproperty
	a_rise_with: assert property (p_rise_with)
		else $error("select rise off");
	property p_gap;
		$rose(link_out.cs_n) |=> link_out.cs_n [*7];
	endproperty
	a_gap: assert property (p_gap)
		else $error("select gap short");
	property p_wr_wait;
		hsel && htrans[1] && hready && hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_wr_wait: assert property (p_wr_wait)
		else $error("write wait wrong");
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay)
		else $error("response not okay");

	c_normal: cover property ($rose(link_out.cs_n) && mon_q.falls == 5'h10);
	c_burst: cover property ($rose(link_out.cs_n) && mon_q.falls == 5'h08);
	c_write: cover property (hsel && htrans[1] && hwrite);
endmodule

bind adc_serial_host_framer adc_framer_asserts u_chk (
	.clock(clock), .rstn(rstn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .link_out(link_out)
);

/* sim/adc_serial_host_framer_tb.sv */
module adc_serial_host_framer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clock = 1'b0;
	logic                    rstn = 1'b0;
	logic                    hsel = 1'b0;
	logic                    hwrite = 1'b0;
	logic [31:0]             haddr = 32'h0;
	logic [31:0]             hwdata = 32'h0;
	logic [1:0]              htrans = 2'b00;
	logic [2:0]              hsize = 3'h2;
	logic [11:0]             value = 12'h5a3;
	logic [31:0]             hrdata;
	logic [31:0]             rd;
	logic                    hreadyout;
	logic                    hresp;
	logic                    sdo;
	adc_host_pkg::link_out_t link_out;
	logic [7:0]              ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20};
	logic [31:0]             rv [5] = '{32'h0, 32'h4, 32'h14, 32'h2, 32'h0};
	int                      n_errors = 0;
	int                      check_count = 0;
	int                      cyc = 0;
	int                      falls, width, t0, t1, i;

	// Clock and cycle count
	always #5 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;

	adc_serial_host_framer u_dut (
		.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .link_out(link_out),
		.serial_result_out(sdo)
	);
	adc_conv_model u_conv (
		.cs_n(link_out.cs_n), .sclk(link_out.sclk), .value(value),
		.data(sdo)
	);

	task test_done;
		if (n_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task hang;
		n_errors++;
		$display("mismatch at %0t: wait expired", $time);
		test_done;
	endtask

	// Wait for hready sampled high at a rising edge
	task wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1)
			hang;
	endtask

	// One single-word transfer, entered just after a rising edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready;
		rd = hrdata;
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// Measure one frame: start cycle, low width, clock falls
	task frame;
		logic p;
		int   n;
		n = 0;
		falls = 0;
		width = 0;
		while (link_out.cs_n !== 1'b0) begin
			@(posedge clock);
			n++;
			if (n > 3000)
				hang;
		end
		t0 = t1;
		t1 = cyc;
		while (link_out.cs_n !== 1'b1) begin
			p = link_out.sclk;
			@(posedge clock);
			width++;
			if (p === 1'b1 && link_out.sclk === 1'b0)
				falls++;
			if (width > 3000)
				hang;
		end
		repeat (2) @(posedge clock);
	endtask

	initial begin
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		// Reset values and an unmapped place
		for (i = 0; i < 5; i++)
			rchk(ra[i], rv[i]);
		// Single normal frame, right-justified result
		xfer(1'b1, adc_host_pkg::CTRL_OFS, 32'h4);
		frame;
		chk(falls, 32'd16);
		chk(width, 32'd128);
		rchk(adc_host_pkg::DATA_OFS, 32'h800005a3);
		rchk(adc_host_pkg::LAST_OFS, 32'h5a3);
		rchk(adc_host_pkg::FRAMES_OFS, 32'h1);
		rchk(adc_host_pkg::DATA_OFS, 32'h0);
		// Power-down burst stores nothing
		xfer(1'b1, adc_host_pkg::CTRL_OFS, 32'h2);
		frame;
		chk(falls, 32'd8);
		chk(width, 32'd64);
		rchk(adc_host_pkg::DATA_OFS, 32'h0);
		// Periodic frames at minimum spacing until the FIFO refuses
		value <= 12'hfff;
		xfer(1'b1, adc_host_pkg::DIV_OFS, 32'h5);
		xfer(1'b1, adc_host_pkg::PERIOD_OFS, 32'h11);
		xfer(1'b1, adc_host_pkg::CTRL_OFS, 32'h1);
		for (i = 0; i < 4; i++)
			frame;
		chk(t1 - t0, 32'd170);
		chk(width, 32'd160);
		repeat (200) @(posedge clock);
		xfer(1'b0, adc_host_pkg::STATUS_OFS, 32'h0);
		chk(rd & 32'h0000ff0c, 32'h0000040c);
		xfer(1'b1, adc_host_pkg::CTRL_OFS, 32'h0);
		repeat (400) @(posedge clock);
		// Drain, then clear the overrun flag
		for (i = 0; i < 4; i++)
			rchk(adc_host_pkg::DATA_OFS, 32'h80000fff);
		rchk(adc_host_pkg::DATA_OFS, 32'h0);
		xfer(1'b1, adc_host_pkg::STATUS_OFS, 32'h8);
		rchk(adc_host_pkg::STATUS_OFS, 32'h2);
		test_done;
	end
endmodule
